// file: hw/fsr_reader.v
/*
  Framebuffer stream reader: fetches pixel words from external memory in
  fixed bursts, buffers them in a dual-clock FIFO and streams them out on
  the pixel clock with a valid/accept handshake.
  Assumes a memory master port that returns burst data with a valid flag,
  a display driver that accepts pixels outside blanking and raises its
  frame sync at the start of vertical blanking, and software that sets
  the framebuffer base over the plain register port.
*/
`timescale 1ns/1ns
`default_nettype none
`include "fsr_defs.vh"

// Functional notes
// - FIFO holds 64 words of 32 bits
// - FIFO written on core, read on pixel clock
// - wait until fill below 32 words
// - every memory read is 32-word burst
// - launch drives length, first address, read request
// - hold request until stall drops, then collect
// - collect until exactly 32 words received
// - each valid word returned while collecting pushed into FIFO
// - wrap-up zeroes tally, adds 128 to offset
// - frame sync synchronised into core domain
// - rising synchronised frame sync raises soft reset
// - soft reset zeroes all core-domain reader counters
// - frame boundary drives FIFO asynchronous clear
// - pixel moves only when valid and accept
// - stream runs in pixel clock domain
// - valid whenever FIFO read side non-empty
// - FIFO pop is valid and accept
// - stream data wired straight from FIFO output
// - tally counts words while collecting
module fsr_reader #(
  parameter DATA_W = 32,
  parameter ADDR_W = 32,
  parameter PTR_W = 7
) (
  input wire core_clk, // system clock, 25 MHz
  input wire rst_n, // synchronous reset, active low
  input wire pixel_clk, // display pixel clock
  input wire [7:0] reg_addr, // register byte address
  input wire [31:0] reg_wdata, // register write data
  input wire reg_write, // register write strobe
  input wire reg_read, // register read strobe
  output reg [31:0] reg_rdata, // read data, cycle after strobe
  output reg [ADDR_W-1:0] master_address, // first pixel address of burst
  output reg [5:0] master_burst_len, // words per burst
  output wire master_read, // burst read request
  input wire master_stall, // memory not yet taking request
  input wire master_return_valid, // returned word valid
  input wire [DATA_W-1:0] master_return_word, // returned pixel word
  input wire frame_sync, // vertical blanking from driver
  output wire source_pixel_valid, // pixel word available
  input wire source_pixel_accept, // sink takes the word
  output wire [DATA_W-1:0] source_pixel_word // pixel word to sink
);

  // ========================================================================
  // burst state machine encoding
  localparam [3:0] ST_WAIT = 4'b0001;
  localparam [3:0] ST_LAUNCH = 4'b0010;
  localparam [3:0] ST_READ = 4'b0100;
  localparam [3:0] ST_DONE = 4'b1000;

  // ========================================================================
  // gray code helpers, used for both pointer crossings
  function [PTR_W-1:0] bin_to_gray;
    input [PTR_W-1:0] bin;
    begin
      bin_to_gray = bin ^ (bin >> 1);
    end
  endfunction

  function [PTR_W-1:0] gray_to_bin;
    input [PTR_W-1:0] gray;
    integer i;
    begin
      gray_to_bin[PTR_W-1] = gray[PTR_W-1];
      for (i = PTR_W - 2; i >= 0; i = i - 1)
      begin
        gray_to_bin[i] = gray_to_bin[i+1] ^ gray[i];
      end
    end
  endfunction

  // ========================================================================
  // declarations
  reg [DATA_W-1:0] fifo_mem [0:(1<<(PTR_W-1))-1];
  reg [3:0] state;
  reg [3:0] next_state;
  reg [ADDR_W-1:0] fb_base;
  reg [ADDR_W-1:0] fetch_offset;
  reg [5:0] tally;
  reg [PTR_W-1:0] wr_ptr;
  reg [PTR_W-1:0] wr_gray;
  reg [PTR_W-1:0] rd_gray_s1;
  reg [PTR_W-1:0] rd_gray_s2;
  reg [PTR_W-1:0] rd_ptr;
  reg [PTR_W-1:0] rd_gray;
  reg [PTR_W-1:0] wr_gray_p1;
  reg [PTR_W-1:0] wr_gray_p2;
  reg sync_s1;
  reg sync_s2;
  reg sync_s3;
  reg soft_reset;
  reg fifo_aclr;
  wire [PTR_W-1:0] wr_fill;
  wire fifo_full;
  wire fifo_push;
  wire fifo_pop;
  wire rd_empty;
  wire frame_rise;

  // ========================================================================
  // frame boundary: two-flop synchroniser then edge detect on later stages
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      sync_s1 <= 1'b0;
      sync_s2 <= 1'b0;
      sync_s3 <= 1'b0;
    end
    else
    begin
      sync_s1 <= frame_sync;
      sync_s2 <= sync_s1;
      sync_s3 <= sync_s2;
    end
  end

  assign frame_rise = sync_s2 & ~sync_s3;

  // soft reset and FIFO clear are registered so the clear never glitches
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      soft_reset <= 1'b0;
      fifo_aclr <= 1'b1;
    end
    else
    begin
      soft_reset <= frame_rise;
      fifo_aclr <= frame_rise;
    end
  end

  // ========================================================================
  // register port: base is writable, status and offset read back
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      fb_base <= `FSR_BASE_RESET;
    end
    else if (reg_write && reg_addr == `FSR_REG_BASE)
    begin
      fb_base <= reg_wdata;
    end
  end

  // read data stands only in the cycle after the strobe, zero elsewhere;
  // the zero default covers reset, idle cycles and unmapped addresses
  always @(posedge core_clk)
  begin
    reg_rdata <= 32'h0000_0000;
    if (rst_n && reg_read)
    begin
      if (reg_addr == `FSR_REG_BASE)
      begin
        reg_rdata <= fb_base;
      end
      else if (reg_addr == `FSR_REG_STATUS)
      begin
        reg_rdata[`FSR_ST_STATE_MSB:`FSR_ST_STATE_LSB] <= state;
        reg_rdata[`FSR_ST_FILL_MSB:`FSR_ST_FILL_LSB] <= wr_fill;
        reg_rdata[`FSR_ST_TALLY_MSB:`FSR_ST_TALLY_LSB] <= tally;
      end
      else if (reg_addr == `FSR_REG_OFFSET)
      begin
        reg_rdata <= fetch_offset;
      end
    end
  end

  // ========================================================================
  // write side fill count; pessimistic, since read pointer arrives late
  assign wr_fill = wr_ptr - gray_to_bin(rd_gray_s2);
  assign fifo_full = (wr_fill == `FSR_FIFO_FULL);
  // only words of the burst in flight are kept; full never occurs in practice
  assign fifo_push = master_return_valid && (state == ST_READ) && !fifo_full;

  // ========================================================================
  // burst state machine, next state
  always @*
  begin
    next_state = state;
    case (state)
      ST_WAIT:
      begin
        if (wr_fill < `FSR_HALF_FULL)
        begin
          next_state = ST_LAUNCH;
        end
      end
      ST_LAUNCH:
      begin
        if (!master_stall)
        begin
          next_state = ST_READ;
        end
      end
      ST_READ:
      begin
        if (fifo_push && tally == `FSR_BURST_LAST)
        begin
          next_state = ST_DONE;
        end
      end
      ST_DONE:
      begin
        next_state = ST_WAIT;
      end
      default:
      begin
        next_state = ST_WAIT;
      end
    endcase
  end

  // state register; frame boundary abandons any burst in progress
  always @(posedge core_clk)
  begin
    if (!rst_n || soft_reset)
    begin
      state <= ST_WAIT;
    end
    else
    begin
      state <= next_state;
    end
  end

  // request held high for the whole launch state
  assign master_read = (state == ST_LAUNCH);

  // address and length latched as the launch state is entered
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      master_address <= `FSR_BASE_RESET;
      master_burst_len <= `FSR_BURST_WORDS;
    end
    else if (state == ST_WAIT && next_state == ST_LAUNCH && !soft_reset)
    begin
      master_address <= fb_base + fetch_offset;
      master_burst_len <= `FSR_BURST_WORDS;
    end
  end

  // ========================================================================
  // per-burst tally and running offset
  always @(posedge core_clk)
  begin
    if (!rst_n || soft_reset)
    begin
      tally <= 6'h00;
      fetch_offset <= `FSR_OFFSET_RESET;
    end
    else if (state == ST_DONE)
    begin
      tally <= 6'h00;
      fetch_offset <= fetch_offset + `FSR_BURST_BYTES;
    end
    else if (fifo_push)
    begin
      tally <= tally + 6'h01;
    end
  end

  // ========================================================================
  // FIFO write side, core clock
  always @(posedge core_clk)
  begin
    if (fifo_push)
    begin
      fifo_mem[wr_ptr[PTR_W-2:0]] <= master_return_word;
    end
  end

  always @(posedge core_clk)
  begin
    if (!rst_n || soft_reset)
    begin
      wr_ptr <= {PTR_W{1'b0}};
      wr_gray <= {PTR_W{1'b0}};
    end
    else if (fifo_push)
    begin
      wr_ptr <= wr_ptr + {{(PTR_W-1){1'b0}}, 1'b1};
      wr_gray <= bin_to_gray(wr_ptr + {{(PTR_W-1){1'b0}}, 1'b1});
    end
  end

  // read pointer crossing into core domain
  always @(posedge core_clk)
  begin
    if (!rst_n || soft_reset)
    begin
      rd_gray_s1 <= {PTR_W{1'b0}};
      rd_gray_s2 <= {PTR_W{1'b0}};
    end
    else
    begin
      rd_gray_s1 <= rd_gray;
      rd_gray_s2 <= rd_gray_s1;
    end
  end

  // ========================================================================
  // FIFO read side, pixel clock; the clear acts without the pixel clock
  assign rd_empty = (rd_gray == wr_gray_p2);
  assign source_pixel_valid = !rd_empty;
  assign fifo_pop = source_pixel_valid && source_pixel_accept;
  assign source_pixel_word = fifo_mem[rd_ptr[PTR_W-2:0]];

  // write pointer crossing into pixel domain
  always @(posedge pixel_clk or posedge fifo_aclr)
  begin
    if (fifo_aclr)
    begin
      wr_gray_p1 <= {PTR_W{1'b0}};
      wr_gray_p2 <= {PTR_W{1'b0}};
    end
    else
    begin
      wr_gray_p1 <= wr_gray;
      wr_gray_p2 <= wr_gray_p1;
    end
  end

  always @(posedge pixel_clk or posedge fifo_aclr)
  begin
    if (fifo_aclr)
    begin
      rd_ptr <= {PTR_W{1'b0}};
      rd_gray <= {PTR_W{1'b0}};
    end
    else if (fifo_pop)
    begin
      rd_ptr <= rd_ptr + {{(PTR_W-1){1'b0}}, 1'b1};
      rd_gray <= bin_to_gray(rd_ptr + {{(PTR_W-1){1'b0}}, 1'b1});
    end
  end

endmodule // fsr_reader

`default_nettype wire

// file: hw/fsr_defs.vh
/*
  Constants for the framebuffer stream reader: register offsets, status
  field positions, reset values, burst and FIFO sizing.
  Assumes it is included by its bare name from the reader's design file.
*/
`ifndef FSR_DEFS_VH
`define FSR_DEFS_VH

// ==========================================================================
// register offsets (byte addresses on the register port)
`define FSR_REG_BASE 8'h00
`define FSR_REG_STATUS 8'h04
`define FSR_REG_OFFSET 8'h08

// ==========================================================================
// status register field positions
`define FSR_ST_STATE_LSB 0
`define FSR_ST_STATE_MSB 3
`define FSR_ST_FILL_LSB 8
`define FSR_ST_FILL_MSB 14
`define FSR_ST_TALLY_LSB 16
`define FSR_ST_TALLY_MSB 21

// ==========================================================================
// reset values
`define FSR_BASE_RESET 32'h0000_0000
`define FSR_OFFSET_RESET 32'h0000_0000

// ==========================================================================
// burst and FIFO sizing
`define FSR_BURST_WORDS 6'h20
`define FSR_BURST_LAST 6'h1f
`define FSR_BURST_BYTES 32'h0000_0080
`define FSR_HALF_FULL 7'h20
`define FSR_FIFO_FULL 7'h40

`endif

// file: testbench/fsr_chk.sv
/* fsr_chk: port assertions for fsr_reader.
   assumes binding to fsr_reader, bind at foot. */
`timescale 1ns/1ns
`default_nettype none
// ==========
// checker
module fsr_chk #(
  parameter DATA_W = 32,
  parameter ADDR_W = 32
) (
  input wire logic core_clk, // core
  input wire logic rst_n, // reset
  input wire logic pixel_clk, // pixel
  input wire logic [7:0] reg_addr, // addr
  input wire logic [31:0] reg_wdata, // wdata
  input wire logic reg_write, // wr
  input wire logic reg_read, // rd
  input wire logic [31:0] reg_rdata, // rdata
  input wire logic [ADDR_W-1:0] master_address, // addr
  input wire logic [5:0] master_burst_len, // len
  input wire logic master_read, // req
  input wire logic master_stall, // stall
  input wire logic master_return_valid, // ret
  input wire logic frame_sync, // vblank
  input wire logic source_pixel_valid, // valid
  input wire logic source_pixel_accept, // accept
  input wire logic [DATA_W-1:0] source_pixel_word // word
);
  logic [6:0] got;
  // words returned since the last taken request
  always @(posedge core_clk)
  begin
    if (!rst_n || (master_read && !master_stall))
      got <= 7'h0;
    else if (master_return_valid)
      got <= got + 7'h1;
  end
  // hold, take and count checks frame time exempt: soft reset may abandon a request
  property p_len;
    @(posedge core_clk) disable iff (!rst_n) master_read |-> master_burst_len == 6'h20;
  endproperty
  a_len: assert property (p_len) else $error("burst length wrong");
  property p_hold;
    @(posedge core_clk) disable iff (!rst_n || frame_sync)
      master_read && master_stall |=> master_read && $stable(master_address);
  endproperty
  a_hold: assert property (p_hold) else $error("request dropped in stall");
  property p_take;
    @(posedge core_clk) disable iff (!rst_n || frame_sync) master_read && !master_stall |=> !master_read [*8];
  endproperty
  a_take: assert property (p_take) else $error("request after take");
  property p_count;
    @(posedge core_clk) disable iff (!rst_n || frame_sync) $rose(master_read) |-> got == 7'h0 || got == 7'h20;
  endproperty
  a_count: assert property (p_count) else $error("launch before 32 words");
  property p_quiet;
    @(posedge core_clk) disable iff (!rst_n) !reg_read |=> reg_rdata == 32'h0;
  endproperty
  a_quiet: assert property (p_quiet) else $error("read data without read");
  property p_base;
    @(posedge core_clk) disable iff (!rst_n)
      reg_write && reg_addr == 8'h00 ##1 reg_read && reg_addr == 8'h00 |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_base: assert property (p_base) else $error("base readback wrong");
  property p_clear;
    @(posedge core_clk) disable iff (!rst_n) $rose(frame_sync) |-> ##[1:8] !source_pixel_valid;
  endproperty
  a_clear: assert property (p_clear) else $error("buffer not cleared");
  property p_stable;
    @(posedge pixel_clk) disable iff (!rst_n || frame_sync)
      source_pixel_valid && !source_pixel_accept |=> source_pixel_valid && $stable(source_pixel_word);
  endproperty
  a_stable: assert property (p_stable) else $error("pixel lost unaccepted");
endmodule // fsr_chk
bind fsr_reader fsr_chk #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) fsr_chk_i (.core_clk, .rst_n, .pixel_clk,
  .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .master_address, .master_burst_len,
  .master_read, .master_stall, .master_return_valid, .frame_sync, .source_pixel_valid,
  .source_pixel_accept, .source_pixel_word);
`default_nettype wire

// file: testbench/fsr_far.sv
/* fsr_far: memory and display sink model.
   assumes one burst at a time, free pixel clock. */
`timescale 1ns/1ns
`default_nettype none
// ==========
// far side
module fsr_far (
  input wire logic core_clk, // core
  input wire logic rst_n, // reset
  input wire logic pixel_clk, // pixel
  input wire logic master_read, // req
  input wire logic [31:0] master_address, // addr
  input wire logic [3:0] stall_cycles, // stall span
  input wire logic slow, // word gaps
  input wire logic blank, // vblank
  output var logic master_stall, // stall
  output var logic master_return_valid, // ret
  output var logic [31:0] master_return_word, // word
  output var logic source_pixel_accept // ready
);
  logic [5:0] left = 6'h0;
  logic [3:0] waited = 4'h0;
  logic [31:0] addr = 32'h0;
  logic [1:0] h = 2'h0;
  initial
  begin
    master_stall = 1'b1;
    master_return_valid = 1'b0;
    master_return_word = 32'h0;
    source_pixel_accept = 1'b0;
  end
  // memory: each word holds its own byte address
  always @(posedge core_clk)
  begin
    master_return_valid <= 1'b0;
    master_return_word <= ~master_return_word; // no stale word off valid
    if (!rst_n)
    begin
      left <= 6'h0;
      waited <= 4'h0;
      master_stall <= 1'b1;
    end
    else if (left != 6'h0)
    begin
      if (!slow || !master_return_valid)
      begin
        master_return_valid <= 1'b1;
        master_return_word <= addr;
        addr <= addr + 32'h4;
        left <= left - 6'h1;
      end
    end
    else if (master_read && !master_stall)
    begin
      left <= 6'h20;
      addr <= master_address;
      master_stall <= 1'b1;
      waited <= 4'h0;
    end
    else if (master_read && waited >= stall_cycles)
      master_stall <= 1'b0;
    else if (master_read)
      waited <= waited + 4'h1;
  end
  // sink: refuses in vblank and one pixel in four
  always @(posedge pixel_clk)
  begin
    h <= h + 2'h1;
    source_pixel_accept <= !blank && h != 2'h3;
  end
endmodule // fsr_far
`default_nettype wire

// file: testbench/fsr_reader_test.sv
/* fsr_reader_test: frames of traffic through fsr_reader.
   assumes fsr_far as far side, fsr_chk bound. */
`timescale 1ns/1ns
`default_nettype none
// ==========
// bench top
module fsr_reader_test;
  logic core_clk = 1'b0;
  logic pixel_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic frame_sync = 1'b0;
  logic blank = 1'b1;
  logic slow = 1'b0;
  logic [3:0] stall_cycles = 4'h0;
  logic [31:0] reg_rdata, master_address, master_return_word, source_pixel_word, rdv;
  logic [5:0] master_burst_len;
  logic master_read, master_stall, master_return_valid, source_pixel_valid, source_pixel_accept;
  logic [31:0] exp_word = 32'h0;
  logic [31:0] frame_base = 32'h0;
  logic [31:0] taken_addr = 32'h0;
  int num_errors = 0;
  int cmp_count = 0;
  int pops = 0;
  // clocks: core 40 ns, pixel 30 ns
  always #20 core_clk = ~core_clk;
  always #15 pixel_clk = ~pixel_clk;
  fsr_reader fsr_reader_i (.core_clk, .rst_n, .pixel_clk, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .master_address, .master_burst_len, .master_read, .master_stall, .master_return_valid,
    .master_return_word, .frame_sync, .source_pixel_valid, .source_pixel_accept, .source_pixel_word);
  fsr_far fsr_far_i (.core_clk, .rst_n, .pixel_clk, .master_read, .master_address, .stall_cycles,
    .slow, .blank, .master_stall, .master_return_valid, .master_return_word, .source_pixel_accept);
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
  begin
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
  begin
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
  end
  endtask
  // data taken at the edge that closes the one cycle in which it stands
  task rd(input logic [7:0] a, output logic [31:0] d);
  begin
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    @(posedge core_clk);
    d = reg_rdata;
  end
  endtask
  task conclude;
  begin
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask
  // stream must walk the framebuffer word by word; restarts at frame sync
  always @(posedge pixel_clk)
  begin
    if (frame_sync)
    begin
      exp_word = frame_base;
      pops = 0;
    end
    else if (source_pixel_valid === 1'b1 && source_pixel_accept === 1'b1)
    begin
      check("pixel", source_pixel_word, exp_word);
      exp_word = exp_word + 32'h4;
      pops++;
    end
  end
  // address of each request the memory takes
  always @(posedge core_clk)
    if (master_read === 1'b1 && master_stall === 1'b0)
      taken_addr <= master_address;
  // main sequence: one frame per base address
  initial
  begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rd(8'h00, rdv);
    check("base_rst", rdv, 32'h0);
    rd(8'h0c, rdv);
    check("unmapped", rdv, 32'h0);
    for (int f = 0; f < 3; f++)
    begin
      blank <= 1'b1;
      slow <= f[0];
      stall_cycles <= 4'(f * 3);
      wr(8'h00, 32'h1000 * (f + 1));
      rd(8'h00, rdv);
      check("base", rdv, 32'h1000 * (f + 1));
      frame_base <= 32'h1000 * (f + 1);
      frame_sync <= 1'b1;
      repeat (300) @(posedge core_clk);
      check("launch", taken_addr, 32'h1000 * (f + 1));
      rd(8'h08, rdv);
      check("offset", rdv, 32'h80);
      rd(8'h04, rdv);
      check("status", rdv, 32'h2001);
      frame_sync <= 1'b0;
      blank <= 1'b0;
      repeat (600) @(posedge core_clk);
      check("pops", pops > 150, 32'h1);
      $display("frame %0d done", f);
    end
    conclude();
  end
  // watchdog: frames need about 3000 core cycles
  initial
  begin
    #(40 * 6000);
    num_errors++;
    conclude();
  end
endmodule // fsr_reader_test
`default_nettype wire
